/* File: src/rxirq_top.sv */
// Receive alarm and event status registers with interrupt masking.
// Assumes all inputs are synchronous to ref_clk and events are pulses.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "rxirq_defs.svh"

module rxirq_top (
  input  wire logic         ref_clk,             // 250 MHz clock
  input  wire logic         nrst,                // Sync reset, active low
  input  wire logic [3:0]   reg_addr,            // Register address
  input  wire logic [7:0]   reg_wdata,           // Write data
  input  wire logic         reg_wr,              // Write strobe
  input  wire logic         reg_rd,              // Read strobe
  output logic [7:0]        reg_rdata,           // Read data, next cycle
  input  wire logic         burst_mode,          // Reads do not clear
  input  wire logic         eight_zero_detect,   // Eight zeros seen
  input  wire logic         sixteen_zero_detect, // Sixteen zeros seen
  input  wire logic         carrier_loss,        // Carrier lost, level
  input  wire logic         yellow_alarm,        // Yellow alarm, level
  input  wire logic         sync_loss,           // Resync in progress
  input  wire logic         code_word_detect,    // Code word seen
  input  wire logic         blue_alarm,          // All-ones alarm, level
  input  wire logic         alignment_change,    // Resync moved alignment
  input  wire logic         fbit_valid,          // Framing bit checked
  input  wire logic         fbit_err,            // That framing bit erred
  input  wire logic         oof_event,           // Out of frame event
  input  wire logic         crc_error,           // CRC error event
  input  wire logic         violation,           // Bipolar violation
  output logic              int_n                // Interrupt, active low
);

  // ==========================================================
  // Registers and nets
  rxirq_pkg::rxirq_byte_t   alarm_stat_ff;
  rxirq_pkg::rxirq_byte_t   nxt_alarm_stat;
  rxirq_pkg::rxirq_byte_t   rx_alarm_irq_mask_ff;
  rxirq_pkg::rxirq_byte_t   rx_event_status_ff;
  rxirq_pkg::rxirq_byte_t   nxt_rx_event_status;
  rxirq_pkg::rxirq_byte_t   rx_event_irq_mask_ff;
  rxirq_pkg::rxirq_byte_t   rdata_ff;
  rxirq_pkg::rxirq_byte_t   nxt_rdata;
  rxirq_pkg::rxirq_byte_t   alarm_cond;
  rxirq_pkg::rxirq_byte_t   event_set;
  rxirq_pkg::rxirq_byte_t   alarm_clr;
  rxirq_pkg::rxirq_byte_t   event_clr;
  logic [`RXIRQ_SEF_WINDOW-1:0] fbit_hist_ff;
  logic [`RXIRQ_SEF_WINDOW-1:0] nxt_fbit_hist;
  logic                     carrier_loss_d_ff;
  logic                     blue_alarm_d_ff;
  logic                     sef_evt;
  logic                     carrier_back_evt;
  logic                     blue_clear_evt;
  logic                     fbit_err_evt;
  logic [`RXIRQ_NUM_CNT-1:0] cnt_inc;
  logic [`RXIRQ_NUM_CNT-1:0] cnt_full;
  logic [15:0]              cnt_val [`RXIRQ_NUM_CNT];
  logic                     rd_alarm_stat;
  logic                     rd_event_stat;
  logic                     wr_alarm_stat;
  logic                     wr_event_stat;
  logic                     irq_any;
  // Decoded mask writes, counter gating and pending sets
  logic                     wr_alarm_mask;
  logic                     wr_event_mask;
  logic                     fe_count_en;
  logic [2:0]               sef_count;
  rxirq_pkg::rxirq_byte_t   alarm_pend;
  rxirq_pkg::rxirq_byte_t   event_pend;

  // ==========================================================
  // Count of errored bits in the framing history
  function automatic logic [2:0] ones6(
    input logic [`RXIRQ_SEF_WINDOW-1:0] v
  );
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < `RXIRQ_SEF_WINDOW; k++) begin
      n = n + {2'h0, v[k]};
    end
    return n;
  endfunction : ones6

  // ==========================================================
  // Access decode
  assign rd_alarm_stat = reg_rd && (reg_addr == `RXIRQ_OFS_ALARM_STAT);
  assign rd_event_stat = reg_rd && (reg_addr == `RXIRQ_OFS_EVENT_STAT);
  assign wr_alarm_stat = reg_wr && (reg_addr == `RXIRQ_OFS_ALARM_STAT);
  assign wr_event_stat = reg_wr && (reg_addr == `RXIRQ_OFS_EVENT_STAT);
  assign wr_alarm_mask = reg_wr && (reg_addr == `RXIRQ_OFS_ALARM_MASK);
  assign wr_event_mask = reg_wr && (reg_addr == `RXIRQ_OFS_EVENT_MASK);

  // A plain read clears all bits; a burst read leaves them
  // The read path captures the pre-clear byte at that same edge
  always_comb begin
    alarm_clr = 8'h00;
    event_clr = 8'h00;
    if (rd_alarm_stat && !burst_mode) begin
      alarm_clr = 8'hFF;
    end
    if (rd_event_stat && !burst_mode) begin
      event_clr = 8'hFF;
    end
    if (wr_alarm_stat) begin
      alarm_clr = alarm_clr | reg_wdata;
    end
    if (wr_event_stat) begin
      event_clr = event_clr | reg_wdata;
    end
  end

  // ==========================================================
  // Alarm status: a standing condition keeps its bit set
  always_comb begin
    alarm_cond = 8'h00;
    alarm_cond[`RXIRQ_A_EIGHT_ZERO]   = eight_zero_detect;
    alarm_cond[`RXIRQ_A_SIXTEEN_ZERO] = sixteen_zero_detect;
    alarm_cond[`RXIRQ_A_CARRIER_LOSS] = carrier_loss;
    alarm_cond[`RXIRQ_A_YELLOW]       = yellow_alarm;
    alarm_cond[`RXIRQ_A_SYNC_LOSS]    = sync_loss;
    alarm_cond[`RXIRQ_A_CODE_WORD]    = code_word_detect;
    alarm_cond[`RXIRQ_A_BLUE]         = blue_alarm;
    alarm_cond[`RXIRQ_A_ALIGN_CHANGE] = alignment_change;
  end

  assign nxt_alarm_stat = (alarm_stat_ff & ~alarm_clr)
                        | alarm_cond;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      alarm_stat_ff <= `RXIRQ_STAT_RST;
    end else begin
      alarm_stat_ff <= nxt_alarm_stat;
    end
  end

  // ==========================================================
  // Severe framing event over the last six framing bits
  assign nxt_fbit_hist = {fbit_hist_ff[`RXIRQ_SEF_WINDOW-2:0], fbit_err};
  assign sef_count     = ones6(nxt_fbit_hist);
  assign sef_evt       = fbit_valid &&
                         (sef_count >= `RXIRQ_SEF_THRESH);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fbit_hist_ff <= '0;
    end else if (fbit_valid) begin
      fbit_hist_ff <= nxt_fbit_hist;
    end
  end

  // ==========================================================
  // Recovery edges of carrier and blue alarm
  // Delayed copies reset to the idle low level, so no false edge
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      carrier_loss_d_ff <= 1'b0;
      blue_alarm_d_ff   <= 1'b0;
    end else begin
      carrier_loss_d_ff <= carrier_loss;
      blue_alarm_d_ff   <= blue_alarm;
    end
  end

  assign carrier_back_evt = carrier_loss_d_ff && !carrier_loss;
  assign blue_clear_evt   = blue_alarm_d_ff && !blue_alarm;
  assign fbit_err_evt     = fbit_valid && fbit_err;

  // ==========================================================
  // Error counters; frame errors are not counted during sync loss
  // Only the violation counter is 16 bits wide
  assign fe_count_en = fbit_err_evt && !sync_loss;
  assign cnt_inc[rxirq_pkg::RXIRQ_CNT_FE]  = fe_count_en;
  assign cnt_inc[rxirq_pkg::RXIRQ_CNT_OOF] = oof_event;
  assign cnt_inc[rxirq_pkg::RXIRQ_CNT_CRC] = crc_error;
  assign cnt_inc[rxirq_pkg::RXIRQ_CNT_BPV] = violation;

  for (genvar i = 0; i < `RXIRQ_NUM_CNT; i++) begin : g_cnt
    localparam int W = (i == int'(rxirq_pkg::RXIRQ_CNT_BPV)) ?
                       `RXIRQ_BPV_CNT_W : `RXIRQ_ERR_CNT_W;
    logic [W-1:0] q;

    rxirq_sat_cnt #(
      .W        (W)
    ) u_cnt (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .inc      (cnt_inc[i]),
      .count_ff (q),
      .full_evt (cnt_full[i])
    );

    assign cnt_val[i] = 16'(q);
  end

  // ==========================================================
  // Event status: sticky, a new event wins over a clear
  always_comb begin
    event_set = 8'h00;
    event_set[`RXIRQ_E_SEVERE_FRAME] = sef_evt;
    event_set[`RXIRQ_E_CARRIER_BACK] = carrier_back_evt;
    event_set[`RXIRQ_E_BLUE_CLEARED] = blue_clear_evt;
    event_set[`RXIRQ_E_FBIT_ERROR]   = fbit_err_evt;
    event_set[`RXIRQ_E_FE_FULL]  = cnt_full[rxirq_pkg::RXIRQ_CNT_FE];
    event_set[`RXIRQ_E_OOF_FULL] = cnt_full[rxirq_pkg::RXIRQ_CNT_OOF];
    event_set[`RXIRQ_E_CRC_FULL] = cnt_full[rxirq_pkg::RXIRQ_CNT_CRC];
    event_set[`RXIRQ_E_VIOL_FULL] = cnt_full[rxirq_pkg::RXIRQ_CNT_BPV];
  end

  assign nxt_rx_event_status = (rx_event_status_ff & ~event_clr)
                             | event_set;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_event_status_ff <= `RXIRQ_STAT_RST;
    end else begin
      rx_event_status_ff <= nxt_rx_event_status;
    end
  end

  // ==========================================================
  // Mask registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_alarm_irq_mask_ff <= `RXIRQ_MASK_RST;
    end else if (wr_alarm_mask) begin
      rx_alarm_irq_mask_ff <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_event_irq_mask_ff <= `RXIRQ_MASK_RST;
    end else if (wr_event_mask) begin
      rx_event_irq_mask_ff <= reg_wdata;
    end
  end

  // ==========================================================
  // Interrupt: bitwise gate of each status bit by its own mask bit
  // Level output: it releases as soon as the last enabled bit clears
  assign alarm_pend = alarm_stat_ff & rx_alarm_irq_mask_ff;
  assign event_pend = rx_event_status_ff & rx_event_irq_mask_ff;
  assign irq_any    = (|alarm_pend) | (|event_pend);
  assign int_n      = !irq_any;

  // ==========================================================
  // Read data, one cycle after the strobe; unmapped reads give zero
  // Counter bytes are live; the violation halves are not paired
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `RXIRQ_OFS_ALARM_STAT: nxt_rdata = alarm_stat_ff;
        `RXIRQ_OFS_ALARM_MASK: nxt_rdata = rx_alarm_irq_mask_ff;
        `RXIRQ_OFS_EVENT_STAT: nxt_rdata = rx_event_status_ff;
        `RXIRQ_OFS_EVENT_MASK: nxt_rdata = rx_event_irq_mask_ff;
        `RXIRQ_OFS_FE_CNT: begin
          nxt_rdata = cnt_val[rxirq_pkg::RXIRQ_CNT_FE][7:0];
        end
        `RXIRQ_OFS_OOF_CNT: begin
          nxt_rdata = cnt_val[rxirq_pkg::RXIRQ_CNT_OOF][7:0];
        end
        `RXIRQ_OFS_CRC_CNT: begin
          nxt_rdata = cnt_val[rxirq_pkg::RXIRQ_CNT_CRC][7:0];
        end
        `RXIRQ_OFS_BPV_CNT_LO: begin
          nxt_rdata = cnt_val[rxirq_pkg::RXIRQ_CNT_BPV][7:0];
        end
        `RXIRQ_OFS_BPV_CNT_HI: begin
          nxt_rdata = cnt_val[rxirq_pkg::RXIRQ_CNT_BPV][15:8];
        end
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule : rxirq_top

/* File: src/rxirq_defs.svh */
// Register offsets, field positions, reset values and sizes of the
// receive alarm interrupt block.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef RXIRQ_DEFS_SVH
`define RXIRQ_DEFS_SVH

// ==========================================================
// Register map
`define RXIRQ_ADDR_W          4
`define RXIRQ_DATA_W          8
`define RXIRQ_OFS_ALARM_STAT  4'h0
`define RXIRQ_OFS_ALARM_MASK  4'h1
`define RXIRQ_OFS_EVENT_STAT  4'h2
`define RXIRQ_OFS_EVENT_MASK  4'h3
`define RXIRQ_OFS_FE_CNT      4'h4
`define RXIRQ_OFS_OOF_CNT     4'h5
`define RXIRQ_OFS_CRC_CNT     4'h6
`define RXIRQ_OFS_BPV_CNT_LO  4'h7
`define RXIRQ_OFS_BPV_CNT_HI  4'h8

// ==========================================================
// Reset values
`define RXIRQ_MASK_RST        8'h00
`define RXIRQ_STAT_RST        8'h00

// ==========================================================
// Alarm status / mask bit positions
`define RXIRQ_A_EIGHT_ZERO    7
`define RXIRQ_A_SIXTEEN_ZERO  6
`define RXIRQ_A_CARRIER_LOSS  5
`define RXIRQ_A_YELLOW        4
`define RXIRQ_A_SYNC_LOSS     3
`define RXIRQ_A_CODE_WORD     2
`define RXIRQ_A_BLUE          1
`define RXIRQ_A_ALIGN_CHANGE  0

// ==========================================================
// Event status / mask bit positions
`define RXIRQ_E_SEVERE_FRAME  7
`define RXIRQ_E_CARRIER_BACK  6
`define RXIRQ_E_BLUE_CLEARED  5
`define RXIRQ_E_FBIT_ERROR    4
`define RXIRQ_E_FE_FULL       3
`define RXIRQ_E_OOF_FULL      2
`define RXIRQ_E_CRC_FULL      1
`define RXIRQ_E_VIOL_FULL     0

// ==========================================================
// Framing window and counter sizes
`define RXIRQ_SEF_WINDOW      6
`define RXIRQ_SEF_THRESH      3'h2
`define RXIRQ_ERR_CNT_W       8
`define RXIRQ_BPV_CNT_W       16
`define RXIRQ_NUM_CNT         4

`endif

/* File: src/rxirq_pkg.sv */
// Types shared by the receive alarm interrupt block.
// Assumes rxirq_defs.svh supplies the sizes.
`include "rxirq_defs.svh"

package rxirq_pkg;

  typedef logic [`RXIRQ_DATA_W-1:0] rxirq_byte_t;
  typedef logic [`RXIRQ_ADDR_W-1:0] rxirq_addr_t;

  // Index of each error counter in the counter array
  typedef enum logic [1:0] {
    RXIRQ_CNT_FE  = 2'h0,
    RXIRQ_CNT_OOF = 2'h1,
    RXIRQ_CNT_CRC = 2'h2,
    RXIRQ_CNT_BPV = 2'h3
  } rxirq_cnt_e;

endpackage : rxirq_pkg

/* File: src/rxirq_sat_cnt.sv */
// Saturating error counter with an event on each hit past saturation.
// Assumes inc is a one-cycle pulse synchronous to ref_clk.
`timescale 1ns/10ps

module rxirq_sat_cnt #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,   // Receive line clock
  input  wire logic         nrst,      // Synchronous reset, active low
  input  wire logic         inc,       // Count one error
  output logic [W-1:0]      count_ff,  // Current count
  output logic              full_evt   // Error seen while saturated
);

  // ==========================================================
  // Count
  logic                     at_max;

  assign at_max   = &count_ff;
  assign full_evt = inc & at_max;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      count_ff <= '0;
    end else if (inc && !at_max) begin
      count_ff <= count_ff + 1'h1;
    end
  end

endmodule : rxirq_sat_cnt

/* File: test/rxirq_chk.sv */
// Checker for the receive alarm interrupt block.
// Assumes it is bound to rxirq_top and sees only its ports.
`timescale 1ns/10ps

module rxirq_chk (
  input wire logic       ref_clk,      // Clock
  input wire logic       nrst,         // Sync reset, active low
  input wire logic [3:0] reg_addr,     // Register address
  input wire logic [7:0] reg_wdata,    // Write data
  input wire logic       reg_wr,       // Write strobe
  input wire logic       reg_rd,       // Read strobe
  input wire logic [7:0] reg_rdata,    // Read data
  input wire logic       carrier_loss, // Carrier lost
  input wire logic       fbit_valid,   // Framing bit checked
  input wire logic       fbit_err,     // Framing bit erred
  input wire logic       crc_error,    // CRC error
  input wire logic       violation,    // Bipolar violation
  input wire logic       int_n         // Interrupt, active low
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Shadow masks, saturating counters and framing window
  logic [7:0]  amask_ff;
  logic [7:0]  emask_ff;
  logic [7:0]  crc_ff;
  logic [15:0] bpv_ff;
  logic [4:0]  win_ff;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      amask_ff <= 8'h00;
      emask_ff <= 8'h00;
      crc_ff   <= 8'h00;
      bpv_ff   <= 16'h0000;
      win_ff   <= 5'h00;
    end else begin
      if (reg_wr && reg_addr == 4'h1) amask_ff <= reg_wdata;
      if (reg_wr && reg_addr == 4'h3) emask_ff <= reg_wdata;
      if (crc_error && crc_ff != 8'hFF) crc_ff <= crc_ff + 8'h01;
      if (violation && bpv_ff != 16'hFFFF) bpv_ff <= bpv_ff + 16'h0001;
      if (fbit_valid) win_ff <= {win_ff[3:0], fbit_err};
    end
  end

  // ==========================================================
  // Assertions
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
  amask_rd_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'h1 |-> reg_rdata == amask_ff)
    else $error("alarm mask readback wrong");
  emask_rd_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'h3 |-> reg_rdata == emask_ff)
    else $error("event mask readback wrong");
  int_quiet_a: assert property (
    amask_ff == 8'h00 && emask_ff == 8'h00 |-> int_n)
    else $error("interrupt with all masked");
  carrier_int_a: assert property (
    carrier_loss && amask_ff[5] |=> !int_n) else $error("carrier irq missing");
  sef_int_a: assert property (
    fbit_valid && $countones({win_ff, fbit_err}) >= 2 && emask_ff[7]
    |=> !int_n) else $error("framing event irq missing");
  crc_full_a: assert property (
    crc_error && crc_ff == 8'hFF && emask_ff[1] |=> !int_n)
    else $error("crc full irq missing");
  viol_full_a: assert property (
    violation && bpv_ff == 16'hFFFF && emask_ff[0] |=> !int_n)
    else $error("violation full irq missing");
  recover_a: assert property (
    $fell(carrier_loss) && emask_ff[6] |-> ##[1:3] !int_n)
    else $error("carrier restored irq missing");

  crc_full_c: cover property (crc_error && crc_ff == 8'hFF && emask_ff[1]);
  sef_c: cover property (fbit_valid && $countones({win_ff, fbit_err}) >= 2);
  recover_c: cover property ($fell(carrier_loss) && emask_ff[6]);
endmodule : rxirq_chk

/* File: test/rx_alarm_interrupt_masking_bench.sv */
// Self-checking bench for the receive alarm interrupt block.
// Assumes rxirq_top and rxirq_chk are compiled before it.
`timescale 1ns/10ps

module rx_alarm_interrupt_masking_bench;
  logic       ref_clk, nrst, reg_wr, reg_rd, burst_mode;
  logic       fbit_valid, fbit_err, int_n;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, al;
  logic [2:0] ev;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cyc = 0;

  rxirq_top dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .burst_mode(burst_mode),
    .eight_zero_detect(al[7]), .sixteen_zero_detect(al[6]),
    .carrier_loss(al[5]), .yellow_alarm(al[4]), .sync_loss(al[3]),
    .code_word_detect(al[2]), .blue_alarm(al[1]),
    .alignment_change(al[0]), .fbit_valid(fbit_valid),
    .fbit_err(fbit_err), .oof_event(ev[2]), .crc_error(ev[1]),
    .violation(ev[0]), .int_n(int_n));

  // ==========================================================
  // Clock, timeout and shared tasks
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      conclude;
    end
  end

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    check(reg_rdata, exp);
  endtask : rdc

  task automatic ck_int(input logic exp);
    @(posedge ref_clk);
    #1;
    check({7'h00, int_n}, {7'h00, exp});
  endtask : ck_int

  task automatic fb(input logic e);
    @(posedge ref_clk);
    fbit_valid <= 1'h1;
    fbit_err <= e;
    @(posedge ref_clk);
    fbit_valid <= 1'h0;
    fbit_err <= 1'h0;
  endtask : fb

  task automatic pulse(input int k);
    @(posedge ref_clk);
    ev[k] <= 1'h1;
    @(posedge ref_clk);
    ev[k] <= 1'h0;
  endtask : pulse

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rdc(4'h1, 8'h00);
    rdc(4'h3, 8'h00);
    rdc(4'h9, 8'h00);
    wr(4'h1, 8'hA5);
    rdc(4'h1, 8'hA5);
    wr(4'h3, 8'h5A);
    rdc(4'h3, 8'h5A);
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h00);
    ck_int(1'h1);
    $display("register test done");
  endtask : t_regs

  task automatic t_alarm;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      al[i] <= 1'h1;
      ck_int(1'h1);
      wr(4'h1, 8'h01 << i);
      ck_int(1'h0);
      @(posedge ref_clk);
      al[i] <= 1'h0;
      ck_int(1'h0);
      rdc(4'h0, 8'h01 << i);
      ck_int(1'h1);
      wr(4'h1, 8'h00);
    end
    rdc(4'h2, 8'h60);
    @(posedge ref_clk);
    al[0] <= 1'h1;
    burst_mode <= 1'h1;
    @(posedge ref_clk);
    al[0] <= 1'h0;
    rdc(4'h0, 8'h01);
    rdc(4'h0, 8'h01);
    @(posedge ref_clk);
    burst_mode <= 1'h0;
    rdc(4'h0, 8'h01);
    rdc(4'h0, 8'h00);
    wr(4'h3, 8'h40);
    @(posedge ref_clk);
    al[5] <= 1'h1;
    @(posedge ref_clk);
    al[5] <= 1'h0;
    repeat (3) @(posedge ref_clk);
    ck_int(1'h0);
    rdc(4'h2, 8'h40);
    rdc(4'h0, 8'h20);
    wr(4'h3, 8'h00);
    $display("alarm test done");
  endtask : t_alarm

  task automatic t_sef;
    wr(4'h3, 8'h80);
    fb(1'h1);
    repeat (5) fb(1'h0);
    fb(1'h1);
    ck_int(1'h1);
    fb(1'h1);
    ck_int(1'h0);
    rdc(4'h2, 8'h90);
    wr(4'h3, 8'h00);
    $display("framing test done");
  endtask : t_sef

  task automatic t_fe;
    @(posedge ref_clk);
    al[3] <= 1'h1;
    fb(1'h1);
    @(posedge ref_clk);
    al[3] <= 1'h0;
    rdc(4'h4, 8'h03);
    rdc(4'h0, 8'h08);
    repeat (252) fb(1'h1);
    rdc(4'h4, 8'hFF);
    wr(4'h3, 8'h08);
    ck_int(1'h1);
    fb(1'h1);
    ck_int(1'h0);
    wr(4'h2, 8'h08);
    ck_int(1'h1);
    rdc(4'h2, 8'h90);
    wr(4'h3, 8'h00);
    $display("frame error test done");
  endtask : t_fe

  task automatic t_sat(input int k, input int n);
    @(posedge ref_clk);
    ev[k] <= 1'h1;
    repeat (n) @(posedge ref_clk);
    ev[k] <= 1'h0;
    ck_int(1'h1);
    pulse(k);
    ck_int(1'h1);
    wr(4'h3, 8'h01 << k);
    ck_int(1'h0);
    rdc(4'h2, 8'h01 << k);
    pulse(k);
    ck_int(1'h0);
    rdc(4'h2, 8'h01 << k);
    wr(4'h3, 8'h00);
    $display("saturation test done");
  endtask : t_sat

  initial begin
    nrst = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    burst_mode = 1'h0;
    fbit_valid = 1'h0;
    fbit_err = 1'h0;
    al = 8'h00;
    ev = 3'h0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'h1;
    t_regs;
    t_alarm;
    t_sef;
    t_fe;
    t_sat(2, 255);
    rdc(4'h5, 8'hFF);
    t_sat(1, 255);
    rdc(4'h6, 8'hFF);
    t_sat(0, 65535);
    rdc(4'h7, 8'hFF);
    rdc(4'h8, 8'hFF);
    conclude;
  end
endmodule : rx_alarm_interrupt_masking_bench

bind rxirq_top rxirq_chk u_chk (.ref_clk(ref_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .carrier_loss(carrier_loss),
  .fbit_valid(fbit_valid), .fbit_err(fbit_err), .crc_error(crc_error),
  .violation(violation), .int_n(int_n));
